/* verilog/blsp_pkg.sv */
// Purpose: shared constants and carriers for the boot lock / self-program control
// Assumes: 16-bit byte addresses on the program memory side
// Notes:   register byte offsets sit on the Avalon-MM slave
package blsp_pkg;

  localparam int          ADDR_W         = 16;
  // register byte offsets
  localparam logic [3:0]  CTRL_OFS       = 4'h0;
  localparam logic [3:0]  LOCK_OFS       = 4'h4;
  localparam logic [3:0]  STAT_OFS       = 4'h8;
  // control register fields
  localparam int          CTRL_READY_IE  = 7;
  localparam int          CTRL_BUSY      = 6;
  localparam int          CTRL_REEN      = 4;
  localparam int          CTRL_SEN       = 0;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  // legal command patterns in the low five bits, then the no-command value
  localparam logic [4:0]  CMD_REEN       = 5'h11;
  localparam logic [4:0]  CMD_LOCKSET    = 5'h09;
  localparam logic [4:0]  CMD_WRITE      = 5'h05;
  localparam logic [4:0]  CMD_ERASE      = 5'h03;
  localparam logic [4:0]  CMD_LOAD       = 5'h01;
  localparam logic [4:0]  CMD_NONE       = 5'h00;
  // lock field layout: [0] lo, [1] hi; 1 = unprogrammed
  localparam logic [1:0]  LOCK_UNPROG    = 2'h3;
  localparam int          LOCK_LO        = 0;
  localparam int          LOCK_HI        = 1;
  // lock-set data positions in the store data byte
  localparam int          LDAT_APP       = 0;
  localparam int          LDAT_BOOT      = 2;
  // store-enable window in clock cycles
  localparam logic [2:0]  WINDOW_CYCLES  = 3'h4;
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;

  typedef enum logic [1:0] {
    SP_IDLE  = 2'b00,
    SP_ARMED = 2'b01,
    SP_BUSY  = 2'b11
  } blsp_prog_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } blsp_bus_t;

  typedef struct packed {
    logic              store;
    logic              load;
    logic [ADDR_W-1:0] target;
    logic [ADDR_W-1:0] exec;
    logic [7:0]        data;
  } blsp_cpu_req_t;

  typedef struct packed {
    logic erase;
    logic write;
    logic buf_load;
    logic buf_clear;
  } blsp_seq_cmd_t;

  typedef struct packed {
    logic store_allow;
    logic load_allow;
    logic fetch_allow;
    logic irq_allow;
  } blsp_access_t;

endpackage : blsp_pkg

/* verilog/blsp_ctrl.sv */
// Purpose: section locks, self-program control register and access gating
// Assumes: cpu request inputs synchronous to i_core_clk, one store per cycle at most
// Notes:   one wait state on every bus access
//
// What this block does
// - keep separate application and boot lock fields, set independently.
// - lock bits only get programmed; only chip erase returns them to ones.
// - general write lock mode never gates self-program stores.
// - general read/write lock mode never gates cpu loads or stores.
// - app lock 11 no limits; 10 blocks stores into application section.
// - app lock 00 blocks app stores and boot-executed loads of app section.
// - app lock 01 blocks boot-executed loads of app section only.
// - app hi programmed and vectors in boot: no interrupts while in app.
// - boot lock 11 no limits; 10 blocks stores into boot section.
// - boot lock 00 blocks boot stores and app-executed loads of boot section.
// - boot lock 01 blocks app-executed loads of boot section only.
// - boot hi programmed and vectors in app: no interrupts while in boot.
// - reset select 1 gives application reset, 0 gives boot start.
// - cpu cannot change the reset select fuse; only external input.
// - ready irq requested while enabled, global enable and store-enable clear.
// - erase or write into concurrent section sets busy; busy denies access.
// - busy clears on re-enable completion or on a buffer load start.
// - control bit 5 always reads zero.
// - re-enable with store-enable plus store within four clocks restores reads.
// - re-enable ignored while erase or write still running.
// - re-enable write during buffer loading discards the loaded data.
// - store-enable and command bits self-clear after four idle clocks.
// - re-enable command also clears the temporary page buffer.
`timescale 1ns/10ps
`default_nettype none

module blsp_ctrl
  import blsp_pkg::*;
#(
  parameter logic [ADDR_W-1:0] HALTING_START = 16'h1800
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_b,
  input  wire logic [3:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output var  logic [31:0]       o_avs_readdata,
  output var  logic              o_avs_waitrequest,
  input  wire blsp_cpu_req_t     i_cpu,
  input  wire logic [ADDR_W-1:0] i_boot_start,
  input  wire logic              i_boot_reset_select,
  input  wire logic              i_ivt_in_boot,
  input  wire logic              i_global_irq_en,
  input  wire logic [3:0]        i_nv_locks,
  input  wire logic              i_ext_lock_wr,
  input  wire logic [3:0]        i_ext_lock_data,
  input  wire logic              i_chip_erase,
  input  wire logic              i_seq_done,
  output var  blsp_access_t      o_access,
  output var  blsp_seq_cmd_t     o_seq,
  output var  logic [ADDR_W-1:0] o_reset_vector,
  output var  logic              o_ready_irq
);

  typedef struct packed {
    blsp_bus_t         bus_st;
    logic [31:0]       readdata;
    logic              ready_irq_enable;
    logic              concurrent_section_busy;
    logic [4:0]        cmd;
    blsp_prog_t        prog;
    logic [2:0]        win;
    logic              buf_dirty;
    logic [1:0]        app_lock;
    logic [1:0]        boot_lock;
    logic              boot_reset_select;
    logic [ADDR_W-1:0] rst_vec;
    logic              loaded;
    blsp_seq_cmd_t     seq;
  } blsp_state_t;

  blsp_state_t st;
  blsp_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // address classification and lock decode

  function automatic logic in_boot(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] start);
    in_boot = (a >= start);
  endfunction : in_boot

  function automatic logic in_conc(input logic [ADDR_W-1:0] a);
    in_conc = (a < HALTING_START);
  endfunction : in_conc

  // lo bit programmed (modes 2 and 3) blocks stores into the section
  function automatic logic store_lock_ok(input logic tgt_boot,
                                         input logic [1:0] app,
                                         input logic [1:0] boot);
    store_lock_ok = tgt_boot ? boot[LOCK_LO] : app[LOCK_LO];
  endfunction : store_lock_ok

  // hi bit programmed (modes 3 and 4) blocks cross-section loads
  function automatic logic load_lock_ok(input logic tgt_boot,
                                        input logic exec_boot,
                                        input logic [1:0] app,
                                        input logic [1:0] boot);
    load_lock_ok = 1'b1;
    if (!tgt_boot && exec_boot && !app[LOCK_HI]) begin
      load_lock_ok = 1'b0;
    end
    if (tgt_boot && !exec_boot && !boot[LOCK_HI]) begin
      load_lock_ok = 1'b0;
    end
  endfunction : load_lock_ok

  logic tgt_boot;
  logic exec_boot;
  logic tgt_conc;
  logic exec_conc;
  logic store_ok;
  logic cmd_legal;
  logic ctrl_wr;
  logic [4:0] wr_cmd;

  // the general memory lock modes are not inputs here at all
  assign tgt_boot  = in_boot(i_cpu.target, i_boot_start);
  assign exec_boot = in_boot(i_cpu.exec, i_boot_start);
  assign tgt_conc  = in_conc(i_cpu.target);
  assign exec_conc = in_conc(i_cpu.exec);
  // self-programming stores only run from the boot section
  assign store_ok  = exec_boot && store_lock_ok(tgt_boot, st.app_lock, st.boot_lock)
                     && !(st.concurrent_section_busy && tgt_conc);
  assign wr_cmd    = i_avs_writedata[4:0];
  assign cmd_legal = (wr_cmd == CMD_REEN) || (wr_cmd == CMD_LOCKSET) ||
                     (wr_cmd == CMD_WRITE) || (wr_cmd == CMD_ERASE) || (wr_cmd == CMD_LOAD);
  assign ctrl_wr   = (st.bus_st == BUS_ACK) && i_avs_write &&
                     (i_avs_address == CTRL_OFS) && i_avs_byteenable[0];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st     = st;
    next_st.seq = '0;

    // nonvolatile copies caught one edge after reset release
    if (!st.loaded) begin
      next_st.loaded            = 1'b1;
      next_st.app_lock          = i_nv_locks[1:0];
      next_st.boot_lock         = i_nv_locks[3:2];
      next_st.boot_reset_select = i_boot_reset_select;
      next_st.rst_vec = i_boot_reset_select ? APP_RESET_ADDR : i_boot_start;
    end

    // self-program sequencing
    case (st.prog)
      SP_IDLE: begin
        next_st.cmd = CMD_NONE;
      end
      SP_ARMED: begin
        if (i_cpu.store) begin
          next_st.prog = SP_IDLE;
          next_st.cmd = CMD_NONE;
          case (st.cmd)
            CMD_ERASE, CMD_WRITE: begin
              if (store_ok) begin
                next_st.prog      = SP_BUSY;
                next_st.cmd       = st.cmd;
                next_st.seq.erase = (st.cmd == CMD_ERASE);
                next_st.seq.write = (st.cmd == CMD_WRITE);
                if (st.cmd == CMD_WRITE) begin
                  next_st.buf_dirty = 1'b0;
                end
                if (tgt_conc) begin
                  next_st.concurrent_section_busy = 1'b1;
                end
              end
            end
            CMD_LOAD: begin
              if (exec_boot) begin
                next_st.seq.buf_load            = 1'b1;
                next_st.buf_dirty               = 1'b1;
                next_st.concurrent_section_busy = 1'b0;
              end
            end
            CMD_REEN: begin
              if (exec_boot) begin
                next_st.concurrent_section_busy = 1'b0;
                next_st.seq.buf_clear           = 1'b1;
                next_st.buf_dirty               = 1'b0;
              end
            end
            CMD_LOCKSET: begin
              if (exec_boot) begin
                // and-in only: software can program but never unprogram
                next_st.app_lock  = st.app_lock & i_cpu.data[LDAT_APP +: 2];
                next_st.boot_lock = st.boot_lock & i_cpu.data[LDAT_BOOT +: 2];
              end
            end
            default: begin
              next_st.cmd = CMD_NONE;
            end
          endcase
        end else if (st.win == 3'h1) begin
          next_st.prog = SP_IDLE;
          next_st.cmd = CMD_NONE;
          next_st.win = 3'h0;
        end else begin
          next_st.win = st.win - 3'h1;
        end
      end
      SP_BUSY: begin
        // store-enable stays high until the sequencer finishes
        if (i_seq_done) begin
          next_st.prog = SP_IDLE;
          next_st.cmd = CMD_NONE;
        end
      end
      default: begin
        next_st.prog = SP_IDLE;
        next_st.cmd = CMD_NONE;
      end
    endcase

    // external programming ands in after cpu lock-set; chip erase overrides both
    if (i_ext_lock_wr) begin
      next_st.app_lock  = next_st.app_lock & i_ext_lock_data[1:0];
      next_st.boot_lock = next_st.boot_lock & i_ext_lock_data[3:2];
    end
    if (i_chip_erase) begin
      next_st.app_lock  = LOCK_UNPROG;
      next_st.boot_lock = LOCK_UNPROG;
    end

    // bus slave: idle -> ack (readdata loaded) -> idle
    case (st.bus_st)
      BUS_IDLE: begin
        if (i_avs_read || i_avs_write) begin
          next_st.bus_st = BUS_ACK;
          case (i_avs_address)
            CTRL_OFS: next_st.readdata = {24'h0000_00, st.ready_irq_enable,
                                          st.concurrent_section_busy, 1'b0, st.cmd};
            LOCK_OFS: next_st.readdata = {28'h000_0000, st.boot_lock, st.app_lock};
            STAT_OFS: next_st.readdata = {28'h000_0000, st.buf_dirty, i_ivt_in_boot,
                                          st.concurrent_section_busy, st.boot_reset_select};
            default:  next_st.readdata = 32'h0000_0000;
          endcase
        end
      end
      BUS_ACK: begin
        next_st.bus_st = BUS_IDLE;
      end
      default: begin
        next_st.bus_st = BUS_IDLE;
      end
    endcase

    if (ctrl_wr) begin
      next_st.ready_irq_enable = i_avs_writedata[CTRL_READY_IE];
      if (st.prog != SP_BUSY) begin
        if (cmd_legal) begin
          next_st.cmd = wr_cmd;
          next_st.prog = SP_ARMED;
          next_st.win = WINDOW_CYCLES;
        end
        if (wr_cmd[CTRL_REEN] && st.buf_dirty) begin
          next_st.seq.buf_clear = 1'b1;
          next_st.buf_dirty     = next_st.seq.buf_load;  // a load landing now still counts
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st                         <= '0;
      st.app_lock                <= LOCK_UNPROG;
      st.boot_lock               <= LOCK_UNPROG;
      st.boot_reset_select       <= 1'b1;
      st.ready_irq_enable        <= CTRL_RESET[CTRL_READY_IE];
      st.concurrent_section_busy <= CTRL_RESET[CTRL_BUSY];
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_avs_readdata    = st.readdata;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && (st.bus_st != BUS_ACK);
  assign o_seq             = st.seq;
  assign o_reset_vector    = st.rst_vec;
  assign o_ready_irq = st.ready_irq_enable && i_global_irq_en && (st.prog == SP_IDLE);

  always_comb begin
    o_access.store_allow = store_ok;
    o_access.load_allow  = load_lock_ok(tgt_boot, exec_boot, st.app_lock, st.boot_lock)
                           && !(st.concurrent_section_busy && tgt_conc);
    o_access.fetch_allow = !(st.concurrent_section_busy && exec_conc);
    o_access.irq_allow   = 1'b1;
    if (!st.app_lock[LOCK_HI] && i_ivt_in_boot && !exec_boot) begin
      o_access.irq_allow = 1'b0;
    end
    if (!st.boot_lock[LOCK_HI] && !i_ivt_in_boot && exec_boot) begin
      o_access.irq_allow = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_armed_idle;
    (st.prog == SP_ARMED) && !i_cpu.store && !ctrl_wr;
  endsequence

  sequence s_reen_store;
    (st.prog == SP_ARMED) && (st.cmd == CMD_REEN) && i_cpu.store && exec_boot && !ctrl_wr;
  endsequence

  a_window_expiry: assert property ((ctrl_wr && cmd_legal && st.prog != SP_BUSY) ##1
      s_armed_idle [*4] |=> (st.prog == SP_IDLE) && (st.cmd == CMD_NONE))
    else $error("store-enable window did not close after four cycles");

  a_reen_restore: assert property (s_reen_store |=> !st.concurrent_section_busy
      && st.seq.buf_clear)
    else $error("re-enable store did not restore section and clear buffer");

  a_busy_ignore: assert property ((st.prog == SP_BUSY) && !i_seq_done |=>
      $stable(st.cmd) && (st.prog == SP_BUSY))
    else $error("command accepted while programming in progress");

  a_busy_set: assert property ((st.prog == SP_ARMED) && i_cpu.store && store_ok && tgt_conc &&
      (st.cmd == CMD_ERASE || st.cmd == CMD_WRITE) |=> st.concurrent_section_busy)
    else $error("busy flag not set by program start in concurrent section");

  a_busy_deny: assert property (st.concurrent_section_busy && tgt_conc |->
      !o_access.load_allow && !o_access.store_allow)
    else $error("access to busy section not denied");

  a_load_clear: assert property ((st.prog == SP_ARMED) && (st.cmd == CMD_LOAD) && i_cpu.store &&
      exec_boot && !ctrl_wr |=> !st.concurrent_section_busy && st.buf_dirty)
    else $error("buffer load did not clear busy flag");

  a_lock_monotone: assert property (!i_chip_erase && st.loaded |=>
      ((st.app_lock & ~$past(st.app_lock)) == 2'h0) &&
      ((st.boot_lock & ~$past(st.boot_lock)) == 2'h0))
    else $error("lock bit unprogrammed without chip erase");

  a_store_app_lock: assert property (!tgt_boot && !st.app_lock[LOCK_LO] |->
      !o_access.store_allow)
    else $error("store into locked application section allowed");

  a_store_boot_lock: assert property (tgt_boot && !st.boot_lock[LOCK_LO] |->
      !o_access.store_allow)
    else $error("store into locked boot section allowed");

  a_load_cross_app: assert property (!tgt_boot && exec_boot && !st.app_lock[LOCK_HI] |->
      !o_access.load_allow)
    else $error("boot load of locked application section allowed");

  a_load_cross_boot: assert property (tgt_boot && !exec_boot && !st.boot_lock[LOCK_HI] |->
      !o_access.load_allow)
    else $error("application load of locked boot section allowed");

  a_irq_mask: assert property ((!st.app_lock[LOCK_HI] && i_ivt_in_boot && !exec_boot) ||
      (!st.boot_lock[LOCK_HI] && !i_ivt_in_boot && exec_boot) |-> !o_access.irq_allow)
    else $error("interrupt not masked in locked section");

  a_ready_irq: assert property ((st.prog != SP_IDLE) |-> !o_ready_irq)
    else $error("ready interrupt while store-enable set");

  a_rsvd_zero: assert property ((st.bus_st == BUS_ACK) && (i_avs_address == CTRL_OFS) &&
      i_avs_read |-> !o_avs_readdata[5])
    else $error("reserved control bit read as one");

  a_vector_stable: assert property (st.loaded |=> $stable(o_reset_vector))
    else $error("reset vector changed after capture");

endmodule : blsp_ctrl

`default_nettype wire

/* sim/blsp_cpu_model.sv */
// Purpose: cpu core side issuing program-memory store and load pulses
// Assumes: one request per call, launched on a rising edge
// Notes:   idle address and data lines toggle so stale values never pass
`timescale 1ns/10ps
`default_nettype none

module blsp_cpu_model
  import blsp_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_store,
  input  wire logic              i_load,
  input  wire logic [ADDR_W-1:0] i_target,
  input  wire logic [ADDR_W-1:0] i_exec,
  input  wire logic [7:0]        i_data,
  output var  blsp_cpu_req_t     o_cpu
);
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cpu <= '0;
    end else if (i_store || i_load) begin
      // one-cycle pulse, issued only when the bench asks
      o_cpu <= '{i_store, i_load, i_target, i_exec, i_data};
    end else begin
      // released lines show no stale value
      o_cpu <= '{1'b0, 1'b0, ~o_cpu.target, ~o_cpu.exec, ~o_cpu.data};
    end
  end
endmodule : blsp_cpu_model

`default_nettype wire

/* sim/tb_boot_lock_and_selfprog_control.sv */
// Purpose: self-checking bench for the lock and self-program control
// Assumes: boot section from 16'h1c00, concurrent section below 16'h1800
// Notes:   bus and cpu requests move only on rising edges
`timescale 1ns/10ps
`default_nettype none

module tb_boot_lock_and_selfprog_control
  import blsp_pkg::*;
;
  logic i_core_clk, i_rst_b, rd, wr, wreq, fuse, ivt, gie, ext_wr, wipe, done, op_st, op_ld;
  logic [3:0]  addr, nv, ext_d;
  logic [31:0] wd, rdata, rv;
  logic [15:0] tgt, exe, rvec;
  logic [7:0]  dat;
  logic        rirq;
  blsp_cpu_req_t cpu;
  blsp_access_t  acc, as;
  blsp_seq_cmd_t seq;
  int failures, compares, n_er, n_bl, n_bc, n_wr;
  logic [1:0] ap, bt;

  blsp_ctrl uut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_cpu(cpu),
    .i_boot_start(16'h1c00), .i_boot_reset_select(fuse), .i_ivt_in_boot(ivt),
    .i_global_irq_en(gie), .i_nv_locks(nv), .i_ext_lock_wr(ext_wr),
    .i_ext_lock_data(ext_d), .i_chip_erase(wipe), .i_seq_done(done), .o_access(acc),
    .o_seq(seq), .o_reset_vector(rvec), .o_ready_irq(rirq));
  blsp_cpu_model cpu_m (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_store(op_st),
    .i_load(op_ld), .i_target(tgt), .i_exec(exe), .i_data(dat), .o_cpu(cpu));

  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    if (seq.erase === 1'b1) n_er++;
    if (seq.buf_load === 1'b1) n_bl++;
    if (seq.buf_clear === 1'b1) n_bc++;
    if (seq.write === 1'b1) n_wr++;
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    addr <= a; wd <= d; wr <= w; rd <= !w;
    // waitrequest and read data taken at the same rising edge
    do @(posedge i_core_clk); while (wreq !== 1'b0);
    rv = rdata;
    wr <= 1'b0; rd <= 1'b0;
  endtask : bus

  task op(input logic st, input logic [15:0] t, input logic [15:0] e, input logic [7:0] d);
    @(posedge i_core_clk);
    op_st <= st; op_ld <= !st; tgt <= t; exe <= e; dat <= d;
    @(posedge i_core_clk);
    op_st <= 1'b0; op_ld <= 1'b0;
    @(negedge i_core_clk);
    as = acc;
    repeat (3) @(posedge i_core_clk);
  endtask : op

  // expected {store, load, irq} allows under a mask
  task axs(input logic [15:0] t, input logic [15:0] e, input logic iv,
           input logic [2:0] exp, input logic [2:0] m);
    @(posedge i_core_clk);
    ivt <= iv;
    op(1'b0, t, e, 8'h00);
    chk("access", exp & m, {as.store_allow, as.load_allow, as.irq_allow} & m);
  endtask : axs

  task pulse(input logic [2:0] which, input logic [3:0] d);
    @(posedge i_core_clk);
    {done, ext_wr, wipe} <= which; ext_d <= d;
    @(posedge i_core_clk);
    {done, ext_wr, wipe} <= 3'h0;
    repeat (2) @(posedge i_core_clk);
  endtask : pulse

  task do_reset(input logic [3:0] locks, input logic f);
    @(posedge i_core_clk);
    i_rst_b <= 1'b0; nv <= locks; fuse <= f;
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_core_clk);
  endtask : do_reset

  task wrap_up;
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge i_core_clk);
    failures++;
    wrap_up;
  end

  initial begin
    {i_rst_b, rd, wr, fuse, ivt, gie, ext_wr, wipe, done, op_st, op_ld} = '0;
    {addr, nv, ext_d, wd, tgt, exe, dat} = '0;
    do_reset(4'hf, 1'b1);
    bus(0, CTRL_OFS, 0); chk("ctrl", 32'h0000_0000, rv);
    bus(0, LOCK_OFS, 0); chk("locks", 32'h0000_000f, rv);
    chk("vector", 32'h0000_0000, {16'h0, rvec});
    bus(1, LOCK_OFS, 0); bus(0, LOCK_OFS, 0); chk("locks", 32'h0000_000f, rv);
    bus(0, 4'hc, 0); chk("unmapped", 32'h0000_0000, rv);
    bus(1, CTRL_OFS, 32'h0000_00a0); bus(0, CTRL_OFS, 0); chk("ctrl", 32'h0000_0080, rv);
    @(posedge i_core_clk) gie <= 1'b1;
    @(negedge i_core_clk) chk("ready irq", 1, rirq);
    @(posedge i_core_clk) gie <= 1'b0;
    @(negedge i_core_clk) chk("ready irq", 0, rirq);
    @(posedge i_core_clk) gie <= 1'b1;
    // command left unused past its window
    bus(1, CTRL_OFS, 32'h0000_0081); repeat (6) @(posedge i_core_clk);
    bus(0, CTRL_OFS, 0); chk("ctrl", 32'h0000_0080, rv);
    op(1, 16'h0200, 16'h1f00, 0); chk("buf loads", 0, n_bl);
    // erase in the concurrent section
    bus(1, CTRL_OFS, 32'h0000_0083); op(1, 16'h0200, 16'h1f00, 0);
    chk("erases", 1, n_er);
    bus(0, CTRL_OFS, 0); chk("busy", 32'h0000_0041, rv & 32'h41);
    chk("ready irq", 0, rirq);
    op(0, 16'h0200, 16'h1f00, 0); chk("load allow", 0, as.load_allow);
    op(0, 16'h1e00, 16'h0100, 0); chk("fetch allow", 0, as.fetch_allow);
    bus(1, CTRL_OFS, 32'h0000_0091); op(1, 16'h0200, 16'h1f00, 0);
    bus(0, CTRL_OFS, 0); chk("busy", 32'h0000_0041, rv & 32'h41);
    chk("clears", 0, n_bc);
    pulse(3'h4, 4'h0);
    bus(0, CTRL_OFS, 0); chk("ctrl", 32'h0000_0040, rv & 32'h51);
    chk("ready irq", 1, rirq);
    bus(1, CTRL_OFS, 32'h0000_0091); op(1, 16'h0200, 16'h1f00, 0);
    bus(0, CTRL_OFS, 0); chk("ctrl", 32'h0000_0080, rv);
    chk("clears", 1, n_bc);
    op(0, 16'h0200, 16'h1f00, 0); chk("load allow", 1, as.load_allow);
    op(0, 16'h1e00, 16'h0100, 0); chk("fetch allow", 1, as.fetch_allow);
    // buffer load clears busy, re-enable then discards the buffer
    bus(1, CTRL_OFS, 32'h0000_0083); op(1, 16'h0200, 16'h1f00, 0); pulse(3'h4, 4'h0);
    bus(1, CTRL_OFS, 32'h0000_0081); op(1, 16'h0200, 16'h1f00, 0);
    chk("buf loads", 1, n_bl);
    bus(0, CTRL_OFS, 0); chk("busy", 0, rv & 32'h40);
    bus(0, STAT_OFS, 0); chk("dirty", 32'h0000_0008, rv & 32'h8);
    bus(1, CTRL_OFS, 32'h0000_0091); repeat (3) @(posedge i_core_clk);
    chk("clears", 2, n_bc);
    bus(0, STAT_OFS, 0); chk("dirty", 0, rv & 32'h8);
    // every pattern of both lock fields, the two fields set apart
    for (int i = 0; i < 4; i++) begin
      ap = 2'(i);
      bt = 2'(3 - i);
      do_reset({bt, ap}, 1'b1);
      bus(0, LOCK_OFS, 0); chk("locks", {28'h0, bt, ap}, rv);
      axs(16'h1900, 16'h1f00, 1, {ap[0], ap[1], 1'b1}, 3'h7);
      axs(16'h1e00, 16'h0100, 1, {1'b0, bt[1], ap[1]}, 3'h3);
      axs(16'h1e00, 16'h1f00, 0, {bt[0], 1'b1, bt[1]}, 3'h7);
    end
    do_reset(4'hf, 1'b0);
    chk("vector", 32'h0000_1c00, {16'h0, rvec});
    @(posedge i_core_clk) fuse <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    chk("vector", 32'h0000_1c00, {16'h0, rvec});
    // page write outside the concurrent section leaves busy clear
    bus(1, CTRL_OFS, 32'h0000_0005); op(1, 16'h1e00, 16'h1f00, 0);
    chk("writes", 1, n_wr);
    bus(0, CTRL_OFS, 0); chk("ctrl", 32'h0000_0005, rv);
    pulse(3'h4, 4'h0);
    bus(1, CTRL_OFS, 32'h0000_0009); op(1, 16'h0000, 16'h1f00, 8'h0e);
    bus(0, LOCK_OFS, 0); chk("locks", 32'h0000_000e, rv);
    pulse(3'h2, 4'hf); bus(0, LOCK_OFS, 0); chk("locks", 32'h0000_000e, rv);
    pulse(3'h2, 4'h7); bus(0, LOCK_OFS, 0); chk("locks", 32'h0000_0006, rv);
    bus(1, CTRL_OFS, 32'h0000_0083); op(1, 16'h0200, 16'h1f00, 0);
    chk("erases", 2, n_er);
    pulse(3'h1, 4'h0); bus(0, LOCK_OFS, 0); chk("locks", 32'h0000_000f, rv);
    wrap_up;
  end
endmodule : tb_boot_lock_and_selfprog_control

`default_nettype wire
